// ---- bench/baud_gen_asserts.sv ----
`timescale 1ns/10ps
`default_nettype none

// Port checks only; register contents are inferred from the bus traffic.
module baud_gen_asserts (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Register port
  input wire baud_pkg::reg_req_t req,
  input wire logic [7:0] rdata,
  // Generator outputs
  input wire logic baud_tick,
  input wire logic sync_clk_out,
  input wire logic sync_master,
  input wire logic rx_level,
  input wire logic rx_bit_strobe
);
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rst_b);

  // A write to one register followed at once by a read of it.
  sequence wr_rd(logic [7:0] a);
    req.wr && req.addr == a ##1 req.rd && req.addr == a;
  endsequence

  // Readback, spare bit and mode decode.
  spare_bit_a: assert property (
    $past(req.rd) && ($past(req.addr) == 8'h98 || $past(req.addr) == 8'h18) |-> !rdata[3])
    else $error("spare control bit reads one");
  div_back_a: assert property (
    wr_rd(baud_pkg::DIV_OFFSET) |=> rdata == $past(req.wdata, 2))
    else $error("divisor readback wrong");
  tcs_back_a: assert property (
    wr_rd(baud_pkg::TCS_OFFSET) |=> (rdata & 8'hF5) == ($past(req.wdata, 2) & 8'hF5))
    else $error("transmit control readback wrong");
  mode_cause_a: assert property (
    $changed(sync_master) |-> $past(req.wr) && $past(req.addr) == baud_pkg::TCS_OFFSET)
    else $error("master mode changed without a write");

  // Generator timing.
  tick_pulse_a: assert property (baud_tick |=> !baud_tick)
    else $error("tick longer than one cycle");
  sync_idle_a: assert property (
    !sync_master && !$past(sync_master) |-> !sync_clk_out)
    else $error("serial clock runs outside master mode");
  sync_step_a: assert property (
    $rose(sync_clk_out) |-> baud_tick || $past(baud_tick))
    else $error("serial clock rose without a tick");

  // Receive vote; the level moves only just after an oversampling tick.
  level_tick_a: assert property (
    $changed(rx_level) |-> $past(baud_tick) || $past(baud_tick, 2) || $past(baud_tick, 3))
    else $error("receive level moved off a tick");
  strobe_a: assert property (
    $changed(rx_level) |-> ##[0:1] rx_bit_strobe ##1 !rx_bit_strobe)
    else $error("no single strobe on level update");
endmodule

bind baud_gen baud_gen_asserts chk_i (
  .mclk(mclk), .rst_b(rst_b), .req(req), .rdata(rdata), .baud_tick(baud_tick),
  .sync_clk_out(sync_clk_out), .sync_master(sync_master), .rx_level(rx_level),
  .rx_bit_strobe(rx_bit_strobe)
);

`default_nettype wire

// ---- bench/tb_baud_gen.sv ----
`timescale 1ns/10ps
`default_nettype none

module tb_baud_gen;
  logic mclk;
  logic rst_b;
  baud_pkg::reg_req_t req;
  logic [7:0] rdata;
  logic shift_empty;
  logic pin;
  logic baud_tick;
  logic sync_clk_out;
  logic sync_master;
  logic rx_level;
  logic rx_bit_strobe;
  logic [7:0] v;
  int n_mismatch;
  int checks_done;
  int c1;
  int c2;
  logic [7:0] tcs_v [4] = '{8'h00, 8'h04, 8'h90, 8'h94};
  int pre [4] = '{64, 16, 2, 2};
  logic [7:0] xs [2] = '{8'h00, 8'hFF};
  logic [7:0] ra [5] = '{8'h98, 8'h18, 8'h99, 8'h55, 8'h18};
  logic [7:0] rw [5] = '{8'hFF, 8'hFF, 8'hA5, 8'hFF, 8'h80};
  logic [7:0] re [5] = '{8'hF7, 8'hF0, 8'hA5, 8'h00, 8'h80};

  baud_gen baud_gen_i (
    .mclk(mclk), .rst_b(rst_b), .req(req), .rdata(rdata), .shift_empty(shift_empty),
    .receive_data_pin(pin), .baud_tick(baud_tick), .sync_clk_out(sync_clk_out),
    .sync_master(sync_master), .rx_level(rx_level), .rx_bit_strobe(rx_bit_strobe)
  );

  // Free-running 40 MHz clock.
  initial
  begin
    mclk = 1'b0;
    forever #12.5 mclk = ~mclk;
  end

  // Compare, count and report.
  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checks_done++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("MISMATCH %0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask

  // Bus tasks; a write leaves only its strobe to drop, so a read may follow at once.
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    req.addr <= a;
    req.wdata <= d;
    req.wr <= 1'b1;
    @(posedge mclk);
    req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    req.addr <= a;
    req.rd <= 1'b1;
    @(posedge mclk);
    req.rd <= 1'b0;
    @(posedge mclk);
    d = rdata;
  endtask

  task automatic cfg(input logic [7:0] t, input logic [7:0] x);
    wr(8'h98, t);
    rd(8'h98, v);
    wr(8'h99, x);
  endtask

  // Cycles to the next tick, or to the next rise of the serial clock.
  task automatic gap(input bit sel, output int n);
    logic p;
    n = 0;
    do
    begin
      p = sync_clk_out;
      @(posedge mclk);
      n++;
    end
    while (!(sel ? (sync_clk_out === 1'b1 && p === 1'b0) : baud_tick === 1'b1) && n < 20000);
  endtask

  task automatic close_out();
    if (n_mismatch == 0 && checks_done > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask

  // The longest rate case needs about 50000 cycles; allow well beyond the whole run.
  initial
  begin
    repeat (95000) @(posedge mclk);
    n_mismatch++;
    close_out();
  end

  // Reset, register map, every rate mode at both divisor limits, slave mode, vote.
  initial
  begin
    req = '0;
    shift_empty = 1'b1;
    pin = 1'b1;
    rst_b = 1'b0;
    n_mismatch = 0;
    checks_done = 0;
    repeat (8) @(posedge mclk);
    rst_b <= 1'b1;
    @(posedge mclk);
    for (int k = 0; k < 4; k++)
    begin
      rd(ra[k], v);
      check(v, k == 0 ? 8'h02 : 8'h00);
    end
    for (int k = 0; k < 5; k++)
    begin
      wr(ra[k], rw[k]);
      rd(ra[k], v);
      check(v, re[k]);
    end
    // The shifter status bit follows the live input, not the stored byte.
    shift_empty <= 1'b0;
    rd(8'h98, v);
    check(v, 8'hF5);
    shift_empty <= 1'b1;
    foreach (tcs_v[m])
      foreach (xs[k])
      begin
        cfg(tcs_v[m], xs[k]);
        check(sync_master, tcs_v[m][7] & tcs_v[m][4]);
        gap(1'b0, c1);
        gap(1'b0, c2);
        check(c2, (xs[k] + 1) * pre[m]);
        repeat (3) @(posedge mclk);
        wr(8'h99, xs[k]);
        gap(1'b0, c2);
        check(c2, c1);
        if (tcs_v[m][4])
        begin
          gap(1'b1, c2);
          gap(1'b1, c2);
          check(c2, 4 * (xs[k] + 1));
        end
      end
    cfg(8'h10, 8'h00);
    c1 = 0;
    repeat (40)
    begin
      @(posedge mclk);
      c1 += baud_tick;
    end
    check(c1, 0);
    // Single-cycle glitches can spoil at most one of the three votes.
    cfg(8'h04, 8'h00);
    pin <= 1'b0;
    repeat (600) @(posedge mclk);
    check(rx_level, 1'b0);
    c1 = 0;
    repeat (16)
    begin
      repeat (36)
      begin
        @(posedge mclk);
        c1 += rx_level;
      end
      pin <= 1'b1;
      @(posedge mclk);
      pin <= 1'b0;
    end
    check(c1, 0);
    @(posedge mclk);
    pin <= 1'b1;
    c2 = 0;
    repeat (600)
    begin
      @(posedge mclk);
      c2 += rx_bit_strobe;
    end
    check(rx_level, 1'b1);
    check(c2 > 1, 1'b1);
    close_out();
  end
endmodule

`default_nettype wire

// ---- src/baud_gen.sv ----
// Summary of operation
// RULE1 - One dedicated 8-bit baud generator serves asynchronous and synchronous modes.
// RULE2 - Free-running 8-bit timer period set by the divisor register.
// RULE3 - In asynchronous mode the high-speed select bit changes the rate.
// RULE4 - In synchronous mode the high-speed select bit is ignored.
// RULE5 - In synchronous mode rate formulas apply only as master; slave clock is external.
// RULE6 - Asynchronous low speed: rate is clock over 64 times divisor plus one.
// RULE7 - Asynchronous high speed: rate is clock over 16 times divisor plus one.
// RULE8 - Synchronous master: rate is clock over 4 times divisor plus one.
// RULE9 - Every divisor 0 to 255 is accepted as unsigned.
// RULE10 - Writing the divisor clears the baud timer at once.
// RULE11 - Receive pin is sampled three times and decided by majority.
// RULE12 - Software picks the nearest divisor and computes the rate error.
// RULE13 - Software may choose high speed for slow rates to cut error.
// RULE14 - Unimplemented bit of both control registers reads zero.
// RULE15 - Asynchronous output is a 16x or 64x bit-rate clock.
// RULE16 - Mode bit one is synchronous, zero is asynchronous.
// RULE17 - In synchronous mode clock source one is master, zero is slave.
// RULE18 - Timer pulses once every divisor-plus-one prescaled ticks then restarts.
// RULE19 - Three votes are taken near the middle of each bit.
`timescale 1ns/10ps
`default_nettype none

module baud_gen #(
  parameter int DIV_WIDTH = 8
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Register port
  input wire baud_pkg::reg_req_t req,
  output logic [7:0] rdata,
  // Status from transmit shifter, same clock
  input wire logic shift_empty,
  // Receive data pin, asynchronous
  input wire logic receive_data_pin,
  // Generator outputs
  output logic baud_tick,
  output logic sync_clk_out,
  output logic sync_master,
  output logic rx_level,
  output logic rx_bit_strobe
);

  // The timer is defined as exactly eight bits wide.
  if (DIV_WIDTH != 8)
  begin : g_width_check
    $error("baud_gen supports only an 8-bit divisor");
  end

  logic [7:0] tcs_r;
  logic [7:0] rcs_r;
  logic [DIV_WIDTH-1:0] baud_divisor_r;
  logic [5:0] pre_r;
  logic [DIV_WIDTH-1:0] timer_r;
  logic tick_r;
  logic sclk_r;
  logic [5:0] ovs_r;
  logic [7:0] rdata_r;
  logic rx_s1_r;
  logic rx_s2_r;
  logic rx_strobe_r;
  logic div_write;
  logic [5:0] pre_last;
  logic [5:0] ovs_last;
  logic [5:0] mid;
  logic sample_now;
  logic vote_now;
  baud_pkg::rate_mode_t mode;

  assign div_write = req.wr && (req.addr == baud_pkg::DIV_OFFSET);

  // Mode select: synchronous bit picks the formula, high speed only counts when async.
  always_comb
  begin
    if (!tcs_r[baud_pkg::SYNC_BIT]) // RULE16
    begin
      if (tcs_r[baud_pkg::HIGH_SPEED_BIT]) // RULE3
        mode = baud_pkg::RATE_ASYNC_HIGH;
      else
        mode = baud_pkg::RATE_ASYNC_LOW;
    end
    else if (tcs_r[baud_pkg::CLK_SRC_BIT]) // RULE4 RULE17
      mode = baud_pkg::RATE_SYNC;
    else
      mode = baud_pkg::RATE_OFF; // RULE5
  end

  // Prescale length before the divisor timer, one less than the ratio, or than half of it when synchronous.
  always_comb
  begin
    case (mode)
      baud_pkg::RATE_ASYNC_LOW: pre_last = 6'(baud_pkg::PRE_LOW - 1); // RULE6
      baud_pkg::RATE_ASYNC_HIGH: pre_last = 6'(baud_pkg::PRE_HIGH - 1); // RULE7
      baud_pkg::RATE_SYNC: pre_last = 6'(baud_pkg::PRE_SYNC / 2 - 1); // RULE8
      default: pre_last = 6'h00;
    endcase
  end

  // Software registers; read-only status bit and unused bits are masked off.
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      tcs_r <= baud_pkg::TCS_RESET;
      rcs_r <= baud_pkg::RCS_RESET;
      baud_divisor_r <= baud_pkg::DIV_RESET;
    end
    else if (req.wr)
    begin
      if (req.addr == baud_pkg::TCS_OFFSET)
        tcs_r <= req.wdata & baud_pkg::TCS_WR_MASK; // RULE14
      if (req.addr == baud_pkg::RCS_OFFSET)
        rcs_r <= req.wdata & baud_pkg::RCS_WR_MASK; // RULE14
      if (div_write)
        baud_divisor_r <= req.wdata; // RULE9
    end
  end

  // Read data, one cycle after the strobe; shifter status reflects live state.
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      rdata_r <= 8'h00;
    else if (req.rd)
    begin
      case (req.addr)
        baud_pkg::TCS_OFFSET:
          rdata_r <= (tcs_r & ~(8'h01 << baud_pkg::SHIFT_EMPTY_BIT)) |
                     ({7'h00, shift_empty} << baud_pkg::SHIFT_EMPTY_BIT); // RULE14
        baud_pkg::RCS_OFFSET: rdata_r <= rcs_r; // RULE14
        baud_pkg::DIV_OFFSET: rdata_r <= baud_divisor_r;
        default: rdata_r <= 8'h00;
      endcase
    end
    else
      rdata_r <= 8'h00;
  end

  // Prescaler; restarts with the timer on a divisor write.
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      pre_r <= 6'h00;
    else if (div_write || mode == baud_pkg::RATE_OFF)
      pre_r <= 6'h00; // RULE10
    else if (pre_r >= pre_last)
      pre_r <= 6'h00;
    else
      pre_r <= pre_r + 6'h01;
  end

  // Free-running divisor timer, one pulse every divisor plus one prescaled ticks.
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      timer_r <= '0;
      tick_r <= 1'b0;
    end
    else if (div_write || mode == baud_pkg::RATE_OFF)
    begin
      timer_r <= '0; // RULE10
      tick_r <= 1'b0;
    end
    else if (pre_r >= pre_last)
    begin
      if (timer_r >= baud_divisor_r) // RULE2 RULE18
      begin
        timer_r <= '0;
        tick_r <= 1'b1; // RULE1
      end
      else
      begin
        timer_r <= timer_r + 1'b1;
        tick_r <= 1'b0;
      end
    end
    else
      tick_r <= 1'b0;
  end

  // Synchronous master clock toggles on each tick while the port is enabled, halving to the 4x ratio.
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      sclk_r <= 1'b0;
    else if (mode != baud_pkg::RATE_SYNC || !rcs_r[baud_pkg::PORT_EN_BIT])
      sclk_r <= 1'b0;
    else if (tick_r)
      sclk_r <= ~sclk_r; // RULE8
  end

  // Two-flop synchroniser on the receive pin.
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      rx_s1_r <= 1'b1;
      rx_s2_r <= 1'b1;
    end
    else
    begin
      rx_s1_r <= receive_data_pin;
      rx_s2_r <= rx_s1_r;
    end
  end

  // Oversample count within a bit: 16 or 64 ticks per bit.
  assign ovs_last = tcs_r[baud_pkg::HIGH_SPEED_BIT] ?
                    6'(baud_pkg::OVS_HIGH - 1) : 6'(baud_pkg::OVS_LOW - 1); // RULE15
  assign mid = {1'b0, ovs_last[5:1]};

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      ovs_r <= 6'h00;
    else if (div_write || mode != baud_pkg::RATE_ASYNC_LOW && mode != baud_pkg::RATE_ASYNC_HIGH)
      ovs_r <= 6'h00;
    else if (tick_r)
      ovs_r <= (ovs_r >= ovs_last) ? 6'h00 : ovs_r + 6'h01; // RULE15
  end

  // Samples at mid-1, mid and mid+1; vote the tick after the last.
  // Free-running phase: a receiver re-aligns by start-bit logic elsewhere.
  assign sample_now = tick_r && (ovs_r == mid - 6'h01 || ovs_r == mid ||
                      ovs_r == mid + 6'h01); // RULE19
  assign vote_now = tick_r && (ovs_r == mid + 6'h02); // RULE19

  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      rx_strobe_r <= 1'b0;
    else
      rx_strobe_r <= vote_now;
  end

  majority_sampler u_vote (
    .mclk(mclk),
    .rst_b(rst_b),
    .din(rx_s2_r),
    .sample(sample_now),
    .vote(vote_now),
    .level(rx_level)
  );

  assign rdata = rdata_r;
  assign baud_tick = tick_r;
  assign sync_clk_out = sclk_r;
  assign sync_master = (mode == baud_pkg::RATE_SYNC);
  assign rx_bit_strobe = rx_strobe_r;

endmodule

`default_nettype wire

// ---- src/baud_pkg.sv ----
package baud_pkg;

  // Register offsets on the plain register port.
  localparam logic [7:0] RCS_OFFSET = 8'h18;
  localparam logic [7:0] TCS_OFFSET = 8'h98;
  localparam logic [7:0] DIV_OFFSET = 8'h99;

  // Field positions in the transmit control register.
  localparam int CLK_SRC_BIT = 7;
  localparam int SYNC_BIT = 4;
  localparam int HIGH_SPEED_BIT = 2;
  localparam int SHIFT_EMPTY_BIT = 1;

  // Field positions in the receive control register.
  localparam int PORT_EN_BIT = 7;

  // Implemented bits, unimplemented bit 3 reads zero.
  localparam logic [7:0] TCS_WR_MASK = 8'hF5;
  localparam logic [7:0] RCS_WR_MASK = 8'hF0;

  // Reset values.
  localparam logic [7:0] TCS_RESET = 8'h02;
  localparam logic [7:0] RCS_RESET = 8'h00;
  localparam logic [7:0] DIV_RESET = 8'h00;

  // Prescale ratios ahead of the divisor timer.
  localparam int PRE_LOW = 64;
  localparam int PRE_HIGH = 16;
  localparam int PRE_SYNC = 4;

  // Ticks per bit in each asynchronous oversampling mode.
  localparam int OVS_LOW = 64;
  localparam int OVS_HIGH = 16;

  // Register port request.
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  // Rate selection derived from mode bits.
  typedef enum logic [1:0] {
    RATE_ASYNC_LOW,
    RATE_ASYNC_HIGH,
    RATE_SYNC,
    RATE_OFF
  } rate_mode_t;

endpackage

// ---- src/majority_sampler.sv ----
`timescale 1ns/10ps
`default_nettype none

// Three-sample majority vote around the middle of a bit.
module majority_sampler (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Synchronised data and sample strobe
  input wire logic din,
  input wire logic sample,
  input wire logic vote,
  // Decided level
  output logic level
);

  logic [2:0] shift_r;
  logic level_r;

  // Collect the latest three samples.
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      shift_r <= 3'h7;
    else if (sample)
      shift_r <= {shift_r[1:0], din}; // RULE11
  end

  // Majority of three decides the level once the samples are in.
  always_ff @(posedge mclk or negedge rst_b)
  begin
    if (!rst_b)
      level_r <= 1'b1;
    else if (vote)
      level_r <= (shift_r[0] & shift_r[1]) | (shift_r[0] & shift_r[2]) |
                 (shift_r[1] & shift_r[2]); // RULE11
  end

  assign level = level_r;

endmodule

`default_nettype wire
